// *** verilog/rac_regs.svh ***
// Purpose: register offsets, field positions, reset values for ramp capture
// Assumes: 32-bit AXI4-Lite, one aligned word per register
// Notes: included by the capture block
`ifndef RAC_REGS_SVH
`define RAC_REGS_SVH

// ***************************************************************
// offsets
// ***************************************************************
`define RAC_OFF_MODE 12'h000
`define RAC_OFF_TRIM 12'h004
`define RAC_OFF_WIDTH 12'h008
`define RAC_OFF_LIMIT 12'h00C
`define RAC_OFF_CAP1 12'h010
`define RAC_OFF_CAP2 12'h014
`define RAC_OFF_CAP3 12'h018
`define RAC_OFF_CAPX 12'h01C
`define RAC_OFF_STAT 12'h020

// ***************************************************************
// fields and reset values
// ***************************************************************
`define RAC_MODE_RATE_BIT 7
`define RAC_MODE_DBL_BIT 2
`define RAC_MODE_RST 8'h00
`define RAC_TRIM_RST 3'h0
`define RAC_WIDTH_RST 16'h0028
`define RAC_CNT_CAP 12'hFFF
`define RAC_AUX_CAL 2'h3

`endif

// *** verilog/rac_pkg.sv ***
// Purpose: types for ramp capture block
// Assumes: nothing
// Notes: bus channels as packed structs
package rac_pkg;
	typedef enum logic [1:0] {RAC_IDLE, RAC_RESET, RAC_RAMP} rac_state_e;
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
	} rac_wreq_s;
	typedef struct packed {
		logic [31:0] data;
		logic [1:0] resp;
	} rac_rrsp_s;
	typedef logic [11:0] rac_count_t;
endpackage

// *** verilog/rac_capture.sv ***
// Purpose: control side of single-slope ramp converter with axi4-lite regs
// Assumes: comparator and sync inputs synchronous to aclk
// Notes: one timer shared by four capture channels
//
// What this block does
// - aux select 00,01,10 route aux inputs; 11 routes reference input
// - three direct and one aux channel convert together on one timer
// - timer is 12 bits, counting from ramp start to crossing
// - each cycle pulse discharges ramp and restarts conversion
// - cycle pulse width comes from a programmable width register
// - mode bit 7 clear counts at half rate, set at full rate
// - each capture register loads timer value when its comparator trips
// - count capped at 4095 and, when the limit register is nonzero, by period minus pulse width
// - double update mode halves the period bounding the window
// - untripped comparator reports zero for that conversion
// - trim register 3 bits, monotonic 0 to 7, resets to zero
// - trim picks one of eight current steps on the current source
`timescale 1ns/100ps
`include "rac_regs.svh"

module rac_capture #(
	parameter int CNT_W = 12,
	parameter int WID_W = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic pwm_cycle_pulse,
	input wire logic [2:0] cmp_direct,
	input wire logic [3:0] cmp_aux,
	output logic ramp_discharge,
	output logic [1:0] aux_select,
	output logic [2:0] ramp_current_source
);
	import rac_pkg::*;

	// ***************************************************************
	// registers
	// ***************************************************************
	logic [7:0] mode_control_reg_ff;
	logic [2:0] ramp_current_trim_ff;
	logic [WID_W-1:0] cycle_pulse_width_ff;
	logic [WID_W-1:0] period_ff;
	logic [CNT_W-1:0] cap_ff [4];
	logic [3:0] done_ff;
	logic [CNT_W-1:0] timer_ff;
	logic [WID_W-1:0] wcnt_ff;
	logic [WID_W-1:0] elap_ff;
	logic half_ff;
	rac_state_e state_ff;
	logic awdone_ff;
	logic wdone_ff;
	logic [31:0] awaddr_ff;
	rac_wreq_s wreq_ff;
	rac_rrsp_s rrsp_ff;
	logic bvalid_ff;
	logic rvalid_ff;

	// ***************************************************************
	// decode
	// ***************************************************************
	function automatic logic [3:0] reg_sel(input logic [31:0] a);
		case (a[11:0])
			`RAC_OFF_MODE: reg_sel = 4'h1;
			`RAC_OFF_TRIM: reg_sel = 4'h2;
			`RAC_OFF_WIDTH: reg_sel = 4'h3;
			`RAC_OFF_LIMIT: reg_sel = 4'h4;
			`RAC_OFF_CAP1: reg_sel = 4'h5;
			`RAC_OFF_CAP2: reg_sel = 4'h6;
			`RAC_OFF_CAP3: reg_sel = 4'h7;
			`RAC_OFF_CAPX: reg_sel = 4'h8;
			`RAC_OFF_STAT: reg_sel = 4'h9;
			default: reg_sel = 4'h0;
		endcase
	endfunction

	wire rate_fast = mode_control_reg_ff[`RAC_MODE_RATE_BIT];
	wire dbl_mode = mode_control_reg_ff[`RAC_MODE_DBL_BIT];
	wire aw_have = awdone_ff | s_axi_awvalid;
	wire w_have = wdone_ff | s_axi_wvalid;
	wire [31:0] waddr = awdone_ff ? awaddr_ff : s_axi_awaddr;
	wire [31:0] wdat = wdone_ff ? wreq_ff.data : s_axi_wdata;
	wire [3:0] wstb = wdone_ff ? wreq_ff.strb : s_axi_wstrb;
	wire do_write = aw_have & w_have & ~bvalid_ff;
	wire [3:0] wsel = reg_sel(waddr);
	wire [3:0] rsel = reg_sel(s_axi_araddr);
	wire do_read = s_axi_arvalid & ~rvalid_ff;

	assign s_axi_awready = ~awdone_ff & ~bvalid_ff;
	assign s_axi_wready = ~wdone_ff & ~bvalid_ff;
	assign s_axi_arready = ~rvalid_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = wreq_ff.addr[1:0];
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rrsp_ff.data;
	assign s_axi_rresp = rrsp_ff.resp;

	// ***************************************************************
	// conversion window
	// ***************************************************************
	// usable span after the pulse, taken from the period halved in double update mode
	wire [WID_W-1:0] per_eff = dbl_mode ? {1'b0, period_ff[WID_W-1:1]}
		: period_ff;
	wire [WID_W-1:0] span = (per_eff > cycle_pulse_width_ff) ?
		per_eff - cycle_pulse_width_ff : '0;
	wire tick = rate_fast | half_ff;
	wire timer_full = (timer_ff == CNT_W'(`RAC_CNT_CAP));
	wire window_end = (elap_ff >= span) & (period_ff != '0);
	wire [3:0] trip = {cmp_aux[aux_select], cmp_direct};

	assign aux_select = mode_control_reg_ff[1:0];
	assign ramp_current_source = ramp_current_trim_ff;
	assign ramp_discharge = (state_ff != RAC_RAMP);

	// ***************************************************************
	// cycle pulse edge
	// ***************************************************************
	// one restart per rising edge, even for a long pulse
	logic pulse_q_ff;
	wire pulse_rise = pwm_cycle_pulse & ~pulse_q_ff;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pulse_q_ff <= 1'b0;
		end else begin
			pulse_q_ff <= pwm_cycle_pulse;
		end
	end

	// ***************************************************************
	// sequencer
	// ***************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff <= RAC_IDLE;
			timer_ff <= '0;
			wcnt_ff <= '0;
			elap_ff <= '0;
			half_ff <= 1'b0;
		end else begin
			half_ff <= ~half_ff;
			case (state_ff)
				RAC_IDLE: begin
					if (pulse_rise) begin
						state_ff <= RAC_RESET;
					end
				end
				RAC_RESET: begin
					timer_ff <= '0;
					elap_ff <= '0;
					half_ff <= 1'b0;
					wcnt_ff <= wcnt_ff + 1'b1;
					if (wcnt_ff + 1'b1 >= cycle_pulse_width_ff) begin
						state_ff <= RAC_RAMP;
						wcnt_ff <= '0;
					end
				end
				RAC_RAMP: begin
					if (pulse_rise) begin
						state_ff <= RAC_RESET;
					end else if (tick && !timer_full && !window_end) begin
						timer_ff <= timer_ff + 1'b1;
					end
					if (!window_end) begin
						elap_ff <= elap_ff + 1'b1;
					end
				end
				default: state_ff <= RAC_IDLE;
			endcase
		end
	end

	// ***************************************************************
	// capture channels
	// ***************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_cap
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					cap_ff[gi] <= '0;
					done_ff[gi] <= 1'b0;
				end else if (state_ff == RAC_RESET) begin
					cap_ff[gi] <= '0;
					done_ff[gi] <= 1'b0;
				end else if (state_ff == RAC_RAMP && !done_ff[gi] &&
					trip[gi] && !window_end) begin
					cap_ff[gi] <= timer_ff;
					done_ff[gi] <= 1'b1;
				end
			end
		end
	endgenerate

	// ***************************************************************
	// axi4-lite write
	// ***************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_control_reg_ff <= `RAC_MODE_RST;
			ramp_current_trim_ff <= `RAC_TRIM_RST;
			cycle_pulse_width_ff <= WID_W'(`RAC_WIDTH_RST);
			period_ff <= '0;
			awdone_ff <= 1'b0;
			wdone_ff <= 1'b0;
			awaddr_ff <= '0;
			wreq_ff <= '0;
			bvalid_ff <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awdone_ff <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdone_ff <= 1'b1;
				wreq_ff.data <= s_axi_wdata;
				wreq_ff.strb <= s_axi_wstrb;
			end
			if (do_write) begin
				awdone_ff <= 1'b0;
				wdone_ff <= 1'b0;
				bvalid_ff <= 1'b1;
				wreq_ff.addr <= (wsel == 4'h0) ? 32'h0000_0002 : '0;
				if (wsel == 4'h1 && wstb[0]) begin
					mode_control_reg_ff <= wdat[7:0];
				end
				if (wsel == 4'h2 && wstb[0]) begin
					ramp_current_trim_ff <= wdat[2:0];
				end
				if (wsel == 4'h3 && wstb[1:0] == 2'h3) begin
					cycle_pulse_width_ff <= wdat[WID_W-1:0];
				end
				if (wsel == 4'h4 && wstb[1:0] == 2'h3) begin
					period_ff <= wdat[WID_W-1:0];
				end
			end else if (bvalid_ff && s_axi_bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	// ***************************************************************
	// axi4-lite read
	// ***************************************************************
	// captured flags and sequencer state
	wire [31:0] stat_word = {16'h0, 4'h0, done_ff, 6'h0, state_ff};

	// zero-extends a count to a bus word
	function automatic logic [31:0] pad_cnt(input logic [CNT_W-1:0] c);
		pad_cnt = {{(32-CNT_W){1'b0}}, c};
	endfunction

	logic [31:0] rmux;
	always_comb begin
		rmux = '0;
		case (rsel)
			4'h1: rmux = {24'h0, mode_control_reg_ff};
			4'h2: rmux = {29'h0, ramp_current_trim_ff};
			4'h3: rmux = {{(32-WID_W){1'b0}}, cycle_pulse_width_ff};
			4'h4: rmux = {{(32-WID_W){1'b0}}, period_ff};
			4'h5: rmux = pad_cnt(cap_ff[0]);
			4'h6: rmux = pad_cnt(cap_ff[1]);
			4'h7: rmux = pad_cnt(cap_ff[2]);
			4'h8: rmux = pad_cnt(cap_ff[3]);
			4'h9: rmux = stat_word;
			default: rmux = '0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rrsp_ff <= '0;
		end else if (do_read) begin
			rvalid_ff <= 1'b1;
			rrsp_ff.data <= rmux;
			rrsp_ff.resp <= (rsel == 4'h0) ? 2'h2 : 2'h0;
		end else if (rvalid_ff && s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end
endmodule

// *** bench/rac_capture_checker.sv ***
// Purpose: port checks for ramp capture
// Assumes: one aclk domain, sync active-low reset
// Notes: bound to rac_capture
`timescale 1ns/100ps
module rac_capture_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic pwm_cycle_pulse,
	input wire logic ramp_discharge,
	input wire logic [1:0] aux_select,
	input wire logic [2:0] ramp_current_source
);
	// ****
	// assertions
	// ****
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid) else $error("bvalid dropped early");
	a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("awready during response");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid) else $error("no read answer");
	a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid) else $error("rvalid dropped early");
	a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("arready while rvalid");
	a_pulse_restart: assert property (
		pwm_cycle_pulse && !$past(pwm_cycle_pulse) && !ramp_discharge
		|=> ramp_discharge) else $error("pulse did not discharge");
	a_trim_reset: assert property (
		$rose(aresetn) |-> ramp_current_source == 3'h0)
		else $error("trim not zero after reset");
	a_aux_reset: assert property (
		$rose(aresetn) |-> aux_select == 2'h0 && ramp_discharge)
		else $error("select or ramp wrong after reset");
	cover property (s_axi_bvalid && s_axi_bready);
	cover property (s_axi_rvalid && s_axi_rready);
	cover property ($fell(ramp_discharge));
endmodule
bind rac_capture rac_capture_checker chk_i (.*);

// *** bench/rac_ramp_model.sv ***
// Purpose: ramp capacitor and comparators
// Assumes: trip times in aclk cycles from ramp start
// Notes: zero trip time on a direct input never trips
`timescale 1ns/100ps
module rac_ramp_model (
	input wire logic aclk,
	input wire logic ramp_discharge,
	input wire logic [11:0] trip_t [4],
	input wire logic [2:0] ramp_current_source,
	output logic [2:0] cmp_direct,
	output logic [3:0] cmp_aux
);
	// ****
	// ramp and trips
	// ****
	logic [11:0] ramp_ff;
	always_ff @(posedge aclk) begin
		if (ramp_discharge)
			ramp_ff <= 12'h000;
		else if (ramp_ff != 12'hFFF)
			ramp_ff <= ramp_ff + 12'h001;
	end
	always_comb begin
		for (int i = 0; i < 3; i++)
			cmp_direct[i] = trip_t[i] != 12'h000 && ramp_ff >= trip_t[i];
		for (int k = 0; k < 3; k++)
			cmp_aux[k] = ramp_ff >= trip_t[3] + 12'(8 * k);
		cmp_aux[3] = ramp_ff >= trip_t[3] + 12'd24 +
			12'(4 * (3'h7 - ramp_current_source));
	end
endmodule

// *** bench/rac_capture_test.sv ***
// Purpose: register and conversion tests for ramp capture
// Assumes: ramp model drives the comparators
// Notes: mode sweep captures compared as differences between channels
`timescale 1ns/100ps
`include "rac_regs.svh"
module rac_capture_test;
	import rac_pkg::*;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
	logic s_axi_bready = 1, s_axi_arvalid = 0, s_axi_rready = 1;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic pwm_cycle_pulse = 0, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, ramp_discharge;
	logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_rdata, rv, c1;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs, aux_select;
	logic [2:0] cmp_direct, ramp_current_source;
	logic [3:0] cmp_aux;
	logic [11:0] trip_t [4] = '{12'd40, 12'd60, 12'd0, 12'd100};
	int miscompares = 0, tests_run = 0, cyc = 0, sh;
	always #2.5 aclk = ~aclk;
	rac_capture dut (.*);
	rac_ramp_model ramp (.*);
	// ****
	// tasks
	// ****
	task automatic chk(input logic [31:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		s_axi_awaddr <= {20'h0, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(negedge aclk);
			ta = s_axi_awready;
			tw = s_axi_wready;
			tb = s_axi_bvalid;
			@(posedge aclk);
			if (ta)
				s_axi_awvalid <= 1'b0;
			if (tw)
				s_axi_wvalid <= 1'b0;
		end while (!tb);
	endtask
	task automatic conv();
		pwm_cycle_pulse <= 1'b1;
		@(posedge aclk);
		pwm_cycle_pulse <= 1'b0;
		repeat (300) @(posedge aclk);
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic ta, tr;
		s_axi_araddr <= {20'h0, a};
		s_axi_arvalid <= 1'b1;
		do begin
			@(negedge aclk);
			ta = s_axi_arready;
			tr = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ta)
				s_axi_arvalid <= 1'b0;
		end while (!tr);
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(d, e);
	endtask
	task automatic summarize();
		if (miscompares == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			summarize();
		end
	end
	// ****
	// tests
	// ****
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rchk(`RAC_OFF_TRIM, 32'h0);
		rchk(`RAC_OFF_WIDTH, 32'h28);
		wr(`RAC_OFF_TRIM, 32'h7);
		chk({29'h0, ramp_current_source}, 32'h7);
		rchk(`RAC_OFF_TRIM, 32'h7);
		s_axi_wstrb <= 4'h0;
		wr(`RAC_OFF_TRIM, 32'h2);
		s_axi_wstrb <= 4'hF;
		rchk(`RAC_OFF_TRIM, 32'h7);
		rd(12'h040, rv, rs);
		chk({30'h0, rs}, 32'h2);
		wr(`RAC_OFF_WIDTH, 32'h4);
		for (int m = 0; m < 8; m++) begin
			wr(`RAC_OFF_MODE, {24'h0, m[2], 5'h0, m[1:0]});
			chk({30'h0, aux_select}, {30'h0, m[1:0]});
			conv();
			rchk(`RAC_OFF_STAT, 32'h0B02);
			sh = m[2] ? 0 : 1;
			rd(`RAC_OFF_CAP1, c1, rs);
			chk({31'h0, c1 != 0}, 32'h1);
			rchk(`RAC_OFF_CAP2, c1 + (32'd20 >> sh));
			rchk(`RAC_OFF_CAP3, 32'h0);
			rchk(`RAC_OFF_CAPX, c1 + ((32'd60 + 32'(8 * m[1:0])) >> sh));
		end
		wr(`RAC_OFF_MODE, 32'h83);
		wr(`RAC_OFF_TRIM, 32'h0);
		for (int t = 0; t < 8; t++) begin
			conv();
			rd(`RAC_OFF_CAPX, c1, rs);
			if (c1 < 32'd130)
				break;
			wr(`RAC_OFF_TRIM, t + 1);
		end
		chk({31'h0, c1 < 32'd130}, 32'h1);
		rchk(`RAC_OFF_TRIM, 32'h6);
		wr(`RAC_OFF_LIMIT, 32'd100);
		wr(`RAC_OFF_MODE, 32'h80);
		conv();
		rchk(`RAC_OFF_CAP1, 32'd40);
		rchk(`RAC_OFF_CAPX, 32'h0);
		wr(`RAC_OFF_MODE, 32'h84);
		conv();
		rchk(`RAC_OFF_CAP1, 32'd40);
		rchk(`RAC_OFF_CAP2, 32'h0);
		summarize();
	end
endmodule
